/* hw/pcl_counter.sv */
/*
  Program counter load logic with its core registers on APB.
  Assumes the execution unit raises one load select per fetch cycle and
  that a push and a pop never occur in the same cycle.
*/
// Overview of operation
// - counter is 15 bits; low byte register is software readable and writable
// - upper seven counter bits have no register; low byte loads take them from the high latch
// - NRST clears the whole counter; POR_N resets only the stack index
// - writing the low byte also loads upper bits from the latch at once
// - computed jump adds offset to low byte, no carry, upper from latch
// - direct call: bits 10..0 from operand, 14..11 from latch bits 6..3
// - accumulator call: low byte from accumulator, upper from latch
// - accumulator branch: counter plus one plus unsigned accumulator
// - relative branch: counter plus one plus signed operand
// - branches compute over full width, latch not involved
// - core registers reached at one address whatever bank is selected
// - unimplemented locations ignore writes and read zero
// - pointer shadows power up unknown, keep contents over other resets
// - push increments index then stores; pop reloads then decrements
// - push and pop leave the high latch unchanged
`timescale 1ns/10ps
module pcl_counter #(
  parameter int PC_W  = pcl_pkg::PC_W,
  parameter int DEPTH = pcl_pkg::DEPTH
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  NRST,
  input  wire logic                  POR_N,
  // ***************************************************************
  // execution unit side
  // ***************************************************************
  input  wire logic                  FETCH_EN,
  input  wire logic [2:0]            LOAD_SEL,
  input  wire logic [1:0]            STACK_OP,
  input  wire logic [7:0]            ACCUM,
  input  wire logic [7:0]            RESULT,
  input  wire logic [10:0]           CALL_OPERAND,
  input  wire logic [8:0]            BRANCH_OPERAND,
  input  wire logic                  LATCH_WE,
  input  wire logic [6:0]            LATCH_WDATA,
  output logic      [PC_W-1:0]       PC,
  output logic      [6:0]            COUNTER_HIGH_LATCH,
  // ***************************************************************
  // APB slave
  // ***************************************************************
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [pcl_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR
);

  localparam int AW = $clog2(DEPTH);

  // ***************************************************************
  // address decode
  // ***************************************************************
  // only the low twelve index bits decode, so no bank select enters
  function automatic logic is_reg(input logic [pcl_pkg::ADDR_W-1:0] a,
                                  input logic [11:0] idx);
    is_reg = (a[13:2] == idx);
  endfunction : is_reg

  logic             apb_wr;
  logic             apb_rd_setup;
  assign apb_wr       = PSEL && PENABLE && PWRITE;
  assign apb_rd_setup = PSEL && !PENABLE && !PWRITE;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [PC_W-1:0]  pc_q, pc_d;
  logic [6:0]       latch_q, latch_d;
  logic [4:0]       sidx_q, sidx_d;
  logic [7:0]       shad_q [4];
  logic [7:0]       shad_d [4];
  logic [31:0]      prdata_q, prdata_d;
  logic             stk_we;
  logic [AW-1:0]    stk_waddr;
  logic [PC_W-1:0]  stk_wdata;
  logic [PC_W-1:0]  tos_rdata;
  logic             pop_pend_q, pop_pend_d;
  logic             low_wr;

  pcl_stack_mem #(
    .WIDTH (PC_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_stack (
    .clk   (SYS_CLK),
    .we    (stk_we),
    .waddr (stk_waddr),
    .wdata (stk_wdata),
    .raddr (sidx_d[AW-1:0]),
    .rdata (tos_rdata)
  );

  assign low_wr = apb_wr && is_reg(PADDR, pcl_pkg::IDX_COUNTER_LOW);

  // ***************************************************************
  // next counter value
  // ***************************************************************
  logic [PC_W-1:0] pc_plus1;
  logic [PC_W-1:0] br_off;
  assign pc_plus1 = PC_W'(pc_q + 1'b1);
  assign br_off   = PC_W'({{(PC_W-9){BRANCH_OPERAND[8]}}, BRANCH_OPERAND});

  always_comb
  begin
    pc_d = pc_q;
    if (FETCH_EN)
    begin
      unique case (pcl_pkg::pcl_load_t'(LOAD_SEL))
        pcl_pkg::PCL_LD_HOLD:   pc_d = pc_q;
        pcl_pkg::PCL_LD_INC:    pc_d = pc_plus1;
        pcl_pkg::PCL_LD_WRLOW:  pc_d = {latch_q, RESULT};
        pcl_pkg::PCL_LD_ADDLOW:
          pc_d = {latch_q, 8'(pc_q[7:0] + ACCUM)};
        pcl_pkg::PCL_LD_CALL:   pc_d = {latch_q[6:3], CALL_OPERAND};
        pcl_pkg::PCL_LD_CALL_VIA_ACCUMULATOR:  pc_d = {latch_q, ACCUM};
        pcl_pkg::PCL_LD_BRW:
          pc_d = PC_W'(pc_plus1 + {{(PC_W-8){1'b0}}, ACCUM});
        pcl_pkg::PCL_LD_BRA:    pc_d = PC_W'(pc_plus1 + br_off);
      endcase
    end
    // software write of the low byte acts like an instruction result
    if (low_wr)
    begin
      pc_d = {latch_q, PWDATA[7:0]};
    end
    // a return reloads from the top of stack read the cycle before
    if (pop_pend_q)
    begin
      pc_d = tos_rdata;
    end
  end

  // ***************************************************************
  // high latch
  // ***************************************************************
  always_comb
  begin
    latch_d = latch_q;
    if (LATCH_WE)
    begin
      latch_d = LATCH_WDATA;
    end
    if (apb_wr && is_reg(PADDR, pcl_pkg::IDX_HIGH_LATCH))
    begin
      latch_d = PWDATA[6:0];
    end
  end

  // ***************************************************************
  // stack index and stack writes
  // ***************************************************************
  logic [4:0] sidx_inc;
  assign sidx_inc = 5'(sidx_q + 1'b1);

  always_comb
  begin
    sidx_d     = sidx_q;
    stk_we     = 1'b0;
    stk_waddr  = sidx_q[AW-1:0];
    stk_wdata  = pc_q;
    pop_pend_d = 1'b0;
    if (FETCH_EN && pcl_pkg::pcl_stack_t'(STACK_OP) == pcl_pkg::PCL_ST_PUSH)
    begin
      sidx_d    = sidx_inc;
      stk_we    = 1'b1;
      stk_waddr = sidx_inc[AW-1:0];
      stk_wdata = pc_plus1;
    end
    else if (FETCH_EN &&
             pcl_pkg::pcl_stack_t'(STACK_OP) == pcl_pkg::PCL_ST_POP)
    begin
      pop_pend_d = 1'b1;
    end
    else if (pop_pend_q)
    begin
      sidx_d = 5'(sidx_q - 1'b1);
    end
    else if (apb_wr && is_reg(PADDR, pcl_pkg::IDX_STACK_INDEX))
    begin
      sidx_d = PWDATA[4:0];
    end
    else if (apb_wr && is_reg(PADDR, pcl_pkg::IDX_STACK_TOP_LOW))
    begin
      stk_we    = 1'b1;
      stk_wdata = {tos_rdata[14:8], PWDATA[7:0]};
    end
    else if (apb_wr && is_reg(PADDR, pcl_pkg::IDX_STACK_TOP_HI))
    begin
      stk_we    = 1'b1;
      stk_wdata = {PWDATA[6:0], tos_rdata[7:0]};
    end
  end

  // ***************************************************************
  // pointer shadows
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_shad
      always_comb
      begin
        shad_d[g] = shad_q[g];
        if (apb_wr && is_reg(PADDR,
            12'(pcl_pkg::IDX_P0_LOW_SHADOW + 12'(g))))
        begin
          shad_d[g] = PWDATA[7:0];
        end
      end
      // no reset on purpose: contents survive every reset
      always_ff @(posedge SYS_CLK)
      begin
        shad_q[g] <= shad_d[g];
      end
    end
  endgenerate

  // ***************************************************************
  // read mux, data taken in the setup cycle
  // ***************************************************************
  always_comb
  begin
    prdata_d = prdata_q;
    if (apb_rd_setup)
    begin
      prdata_d = 32'h0000_0000;
      if (is_reg(PADDR, pcl_pkg::IDX_COUNTER_LOW))
        prdata_d[7:0] = pc_q[7:0];
      else if (is_reg(PADDR, pcl_pkg::IDX_HIGH_LATCH))
        prdata_d[6:0] = latch_q;
      else if (is_reg(PADDR, pcl_pkg::IDX_P0_LOW_SHADOW))
        prdata_d[7:0] = shad_q[0];
      else if (is_reg(PADDR, pcl_pkg::IDX_P0_HIGH_SHAD))
        prdata_d[7:0] = shad_q[1];
      else if (is_reg(PADDR, pcl_pkg::IDX_P1_LOW_SHADOW))
        prdata_d[7:0] = shad_q[2];
      else if (is_reg(PADDR, pcl_pkg::IDX_P1_HIGH_SHAD))
        prdata_d[7:0] = shad_q[3];
      else if (is_reg(PADDR, pcl_pkg::IDX_STACK_INDEX))
        prdata_d[4:0] = sidx_q;
      else if (is_reg(PADDR, pcl_pkg::IDX_STACK_TOP_LOW))
        prdata_d[7:0] = tos_rdata[7:0];
      else if (is_reg(PADDR, pcl_pkg::IDX_STACK_TOP_HI))
        prdata_d[6:0] = tos_rdata[14:8];
      else if (is_reg(PADDR, pcl_pkg::IDX_PC_STATUS))
        prdata_d[PC_W-1:0] = pc_q;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pc_q       <= pcl_pkg::PC_RST;
      latch_q    <= pcl_pkg::LATCH_RST;
      prdata_q   <= 32'h0000_0000;
      pop_pend_q <= 1'b0;
    end
    else
    begin
      pc_q       <= pc_d;
      latch_q    <= latch_d;
      prdata_q   <= prdata_d;
      pop_pend_q <= pop_pend_d;
    end
  end

  // index is reset only by power-on; the stack contents are never reset
  always_ff @(posedge SYS_CLK or negedge POR_N)
  begin
    if (!POR_N)
    begin
      sidx_q <= pcl_pkg::STACK_IDX_RST;
    end
    else
    begin
      sidx_q <= sidx_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign PC                 = pc_q;
  assign COUNTER_HIGH_LATCH = latch_q;
  assign PRDATA             = prdata_q;
  assign PREADY             = 1'b1;
  assign PSLVERR            = 1'b0;

endmodule : pcl_counter

/* hw/pcl_pkg.sv */
/*
  Package for the program counter load logic: register offsets, widths,
  reset values and the load-select encoding.
  Assumes byte addressing on APB, each register one aligned 32-bit word.
*/
package pcl_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int PC_W     = 15;
  localparam int UPPER_W  = 7;
  localparam int IDX_W    = 5;
  localparam int DEPTH    = 16;
  localparam int ADDR_W   = 14;

  // ***************************************************************
  // register indices as printed, byte address is four times these
  // ***************************************************************
  localparam logic [11:0] IDX_COUNTER_LOW   = 12'hf82;
  localparam logic [11:0] IDX_HIGH_LATCH    = 12'hf8a;
  localparam logic [11:0] IDX_P0_LOW_SHADOW = 12'hfe8;
  localparam logic [11:0] IDX_P0_HIGH_SHAD  = 12'hfe9;
  localparam logic [11:0] IDX_P1_LOW_SHADOW = 12'hfea;
  localparam logic [11:0] IDX_P1_HIGH_SHAD  = 12'hfeb;
  localparam logic [11:0] IDX_STACK_INDEX   = 12'hfed;
  localparam logic [11:0] IDX_STACK_TOP_LOW = 12'hfee;
  localparam logic [11:0] IDX_STACK_TOP_HI  = 12'hfef;
  localparam logic [11:0] IDX_PC_STATUS     = 12'hff0;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [14:0] PC_RST         = 15'h0000;
  localparam logic [6:0]  LATCH_RST      = 7'h00;
  localparam logic [4:0]  STACK_IDX_RST  = 5'h1f;

  // ***************************************************************
  // load select from the execution unit
  // ***************************************************************
  typedef enum logic [2:0] {
    PCL_LD_HOLD    = 3'h0,
    PCL_LD_INC     = 3'h1,
    PCL_LD_WRLOW   = 3'h2,
    PCL_LD_ADDLOW  = 3'h3,
    PCL_LD_CALL    = 3'h4,
    PCL_LD_CALL_VIA_ACCUMULATOR   = 3'h5,
    PCL_LD_BRW     = 3'h6,
    PCL_LD_BRA     = 3'h7
  } pcl_load_t;

  typedef enum logic [1:0] {
    PCL_ST_NONE = 2'h0,
    PCL_ST_PUSH = 2'h1,
    PCL_ST_POP  = 2'h3
  } pcl_stack_t;

endpackage : pcl_pkg

/* hw/pcl_stack_mem.sv */
/*
  Return-address memory of the counter block: one write port, one read
  port, registered read data.
  Assumes the caller orders push and pop against the stack index.
*/
`timescale 1ns/10ps
module pcl_stack_mem #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset: contents survive every reset, as a real stack does
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
  end

endmodule : pcl_stack_mem

/* test/pcl_counter_properties.sv */
/*
  Checker for the counter load behaviour, bound to the counter block.
  Assumes the bind hands on PC_W and connects the ports by name.
*/
`timescale 1ns/10ps
module pcl_counter_properties #(
  parameter int PC_W = 15
) (
  input wire logic            SYS_CLK,
  input wire logic            NRST,
  input wire logic            FETCH_EN,
  input wire logic [2:0]      LOAD_SEL,
  input wire logic [1:0]      STACK_OP,
  input wire logic [7:0]      ACCUM,
  input wire logic [7:0]      RESULT,
  input wire logic [10:0]     CALL_OPERAND,
  input wire logic [8:0]      BRANCH_OPERAND,
  input wire logic            LATCH_WE,
  input wire logic [6:0]      LATCH_WDATA,
  input wire logic [PC_W-1:0] PC,
  input wire logic [6:0]      COUNTER_HIGH_LATCH,
  input wire logic            PSEL,
  input wire logic            PWRITE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic pop_q;
  logic pop_d;
  // any bus write or pending pop may override the instruction load
  wire  bus_wr = PSEL && PWRITE;
  wire  calm   = FETCH_EN && !bus_wr && !pop_q && STACK_OP != 2'h3;
  always_comb pop_d = FETCH_EN && STACK_OP == 2'h3;
  always_ff @(posedge SYS_CLK or negedge NRST)
    if (!NRST) pop_q <= 1'b0;
    else pop_q <= pop_d;
  // *******************************
  // counter loads
  // *******************************
  a_reset_clear: assert property ($rose(NRST) |-> PC == '0)
    else $error("pc not clear");
  a_inc_wrap: assert property (calm && LOAD_SEL == 3'h1 |=>
    PC == $past(PC) + 15'h1) else $error("inc");
  a_low_write: assert property (calm && LOAD_SEL == 3'h2 |=>
    PC == {$past(COUNTER_HIGH_LATCH), $past(RESULT)}) else $error("low");
  a_add_nocarry: assert property (calm && LOAD_SEL == 3'h3 |=>
    PC == {$past(COUNTER_HIGH_LATCH), $past(PC[7:0]) + $past(ACCUM)})
    else $error("add");
  a_call_direct: assert property (calm && LOAD_SEL == 3'h4 |=>
    PC == {$past(COUNTER_HIGH_LATCH[6:3]), $past(CALL_OPERAND)})
    else $error("call");
  a_call_accum: assert property (calm && LOAD_SEL == 3'h5 |=>
    PC == {$past(COUNTER_HIGH_LATCH), $past(ACCUM)}) else $error("call_via_accumulator");
  a_branch_accum: assert property (calm && LOAD_SEL == 3'h6 |=>
    PC == $past(PC) + 15'h1 + {7'h0, $past(ACCUM)}) else $error("brw");
  a_branch_rel: assert property (calm && LOAD_SEL == 3'h7 |=>
    PC == $past(PC) + 15'h1 + {{6{$past(BRANCH_OPERAND[8])}},
    $past(BRANCH_OPERAND)}) else $error("bra");
  a_idle_hold: assert property (!FETCH_EN && !bus_wr && !pop_q |=>
    $stable(PC)) else $error("pc moved");
  a_latch_load: assert property (LATCH_WE && !bus_wr |=>
    COUNTER_HIGH_LATCH == $past(LATCH_WDATA)) else $error("latch");
  a_stack_latch: assert property (FETCH_EN && STACK_OP != 2'h0 &&
    !LATCH_WE && !bus_wr |=> $stable(COUNTER_HIGH_LATCH)) else $error("ls");
  c_rel_back: cover property (calm && LOAD_SEL == 3'h7 && BRANCH_OPERAND[8]);
  c_push: cover property (FETCH_EN && STACK_OP == 2'h1);
  c_pop: cover property (pop_q);
endmodule : pcl_counter_properties

/* test/pcl_exec_model.sv */
/*
  Execution unit model that feeds the counter block one step at a time.
  Assumes the bench calls one task at a time, after reset.
*/
`timescale 1ns/10ps
module pcl_exec_model (
  input  wire logic   clk,
  output logic        fetch_en,
  output logic [2:0]  load_sel,
  output logic [1:0]  stack_op,
  output logic [7:0]  accum,
  output logic [7:0]  result,
  output logic [10:0] call_op,
  output logic [8:0]  br_op,
  output logic        latch_we,
  output logic [6:0]  latch_wdata
);
  initial
  begin
    fetch_en = 1'b0;
    load_sel = 3'h0;
    stack_op = 2'h0;
    {accum, result, call_op, br_op} = '0;
    latch_we = 1'b0;
    latch_wdata = 7'h00;
  end
  task automatic step(input logic [2:0] sel, input logic [1:0] op,
                      input logic [10:0] v);
    @(posedge clk);
    fetch_en <= 1'b1;
    load_sel <= sel;
    stack_op <= op;
    {accum, result, call_op, br_op} <= {v[7:0], v[7:0], v, v[8:0]};
    @(posedge clk);
    fetch_en <= 1'b0;
    stack_op <= 2'h0;
    // operands stale once the step is over
    {accum, result, call_op, br_op} <= ~{v[7:0], v[7:0], v, v[8:0]};
  endtask : step
  task automatic latch(input logic [6:0] v);
    @(posedge clk);
    latch_we <= 1'b1;
    latch_wdata <= v;
    @(posedge clk);
    latch_we <= 1'b0;
    latch_wdata <= ~v;
  endtask : latch
endmodule : pcl_exec_model

/* test/tb_pcl_counter.sv */
/*
  Self-checking bench for the counter block, execution unit model and APB.
  Assumes a 50 MHz clock and the register indices of the package.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((e) !== (g)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_pcl_counter;
  logic        sys_clk, nrst, por_n, fetch_en, latch_we;
  logic [2:0]  load_sel;
  logic [1:0]  stack_op;
  logic [7:0]  accum, result;
  logic [10:0] call_op;
  logic [8:0]  br_op;
  logic [6:0]  latch_wdata, high_latch;
  logic [14:0] pc;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int          bad_count, n_compared;
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  pcl_exec_model u_pcl_exec_model (.clk(sys_clk), .fetch_en(fetch_en),
    .load_sel(load_sel), .stack_op(stack_op), .accum(accum),
    .result(result), .call_op(call_op), .br_op(br_op),
    .latch_we(latch_we), .latch_wdata(latch_wdata));
  pcl_counter u_pcl_counter (.SYS_CLK(sys_clk), .NRST(nrst), .POR_N(por_n),
    .FETCH_EN(fetch_en), .LOAD_SEL(load_sel), .STACK_OP(stack_op),
    .ACCUM(accum), .RESULT(result), .CALL_OPERAND(call_op),
    .BRANCH_OPERAND(br_op), .LATCH_WE(latch_we), .LATCH_WDATA(latch_wdata),
    .PC(pc), .COUNTER_HIGH_LATCH(high_latch), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [11:0] i,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 2'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      bad_count++;
      print_verdict();
    end
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  // pc settles after the load edge
  task automatic pcchk(input logic [14:0] x);
    #1;
    `CHK("pc", x, pc)
  endtask : pcchk
  task automatic t_reset;
    `CHK("pc", 15'h0000, pc)
    `CHK("latch", 7'h00, high_latch)
    apb(1'b0, pcl_pkg::IDX_STACK_INDEX, 32'h0, r);
    `CHK("stack index", 5'h1f, r[4:0])
    $display("test reset done");
  endtask : t_reset
  task automatic t_loads;
    u_pcl_exec_model.latch(7'h55);
    pcchk(15'h0000);
    u_pcl_exec_model.step(3'h2, 2'h0, 11'h034);
    pcchk(15'h5534);
    u_pcl_exec_model.step(3'h3, 2'h0, 11'h0f0);
    pcchk(15'h5524);
    u_pcl_exec_model.step(3'h7, 2'h0, 11'h1f0);
    pcchk(15'h5515);
    u_pcl_exec_model.step(3'h6, 2'h0, 11'h0ff);
    pcchk(15'h5615);
    u_pcl_exec_model.step(3'h7, 2'h0, 11'h010);
    pcchk(15'h5626);
    u_pcl_exec_model.step(3'h5, 2'h1, 11'h012);
    pcchk(15'h5512);
    apb(1'b0, pcl_pkg::IDX_STACK_INDEX, 32'h0, r);
    `CHK("stack index", 5'h00, r[4:0])
    u_pcl_exec_model.step(3'h4, 2'h1, 11'h7ab);
    pcchk(15'h57ab);
    u_pcl_exec_model.step(3'h0, 2'h3, 11'h0);
    @(posedge sys_clk);
    pcchk(15'h5513);
    u_pcl_exec_model.step(3'h0, 2'h3, 11'h0);
    @(posedge sys_clk);
    pcchk(15'h5627);
    `CHK("latch", 7'h55, high_latch)
    apb(1'b0, pcl_pkg::IDX_STACK_INDEX, 32'h0, r);
    `CHK("stack index", 5'h1f, r[4:0])
    u_pcl_exec_model.latch(7'h7f);
    u_pcl_exec_model.step(3'h2, 2'h0, 11'h0ff);
    u_pcl_exec_model.step(3'h1, 2'h0, 11'h0);
    pcchk(15'h0000);
    $display("test loads done");
  endtask : t_loads
  task automatic t_apb;
    u_pcl_exec_model.latch(7'h2a);
    apb(1'b1, pcl_pkg::IDX_COUNTER_LOW, 32'h77, r);
    pcchk(15'h2a77);
    apb(1'b0, pcl_pkg::IDX_COUNTER_LOW, 32'h0, r);
    `CHK("low byte", 8'h77, r[7:0])
    apb(1'b1, 12'hfec, 32'hff, r);
    apb(1'b0, 12'hfec, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    `CHK("no error", 1'b0, pslverr)
    `CHK("ready", 1'b1, pready)
    apb(1'b0, pcl_pkg::IDX_PC_STATUS, 32'h0, r);
    `CHK("pc status", 32'h0000_2a77, r)
    // point at the oldest return address left by the loads test
    apb(1'b1, pcl_pkg::IDX_STACK_INDEX, 32'h0, r);
    apb(1'b0, pcl_pkg::IDX_STACK_TOP_LOW, 32'h0, r);
    `CHK("top low", 8'h27, r[7:0])
    apb(1'b0, pcl_pkg::IDX_STACK_TOP_HI, 32'h0, r);
    `CHK("top high", 7'h56, r[6:0])
    apb(1'b1, pcl_pkg::IDX_P0_LOW_SHADOW, 32'h5a, r);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    pcchk(15'h0000);
    apb(1'b0, pcl_pkg::IDX_P0_LOW_SHADOW, 32'h0, r);
    `CHK("shadow", 8'h5a, r[7:0])
    $display("test apb done");
  endtask : t_apb
  initial
  begin
    {nrst, por_n, psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_loads();
    t_apb();
    print_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end
endmodule : tb_pcl_counter
bind pcl_counter pcl_counter_properties #(.PC_W(PC_W)) u_props (.*);
